// File: dv/iicu_field_model.sv
// iicu_field_model: proximity sensors, a pulse encoder and an absolute encoder.
// assumes the bench calls its tasks; pins change on the falling edge.
`timescale 1ns/100ps
`default_nettype none
module iicu_field_model (
    input wire logic sys_clk,
    output logic [3:0] in_pin,
    output logic [1:0] hsc_a,
    output logic [1:0] hsc_b,
    output logic [11:0] abs_gray
);
    ////////////////////////////////////////////////////////////////
    // sensors idle off, encoder at position zero
    initial begin
        {in_pin, hsc_a, hsc_b, abs_gray} = 20'h00000;
    end
    // held five cycles so the synchroniser surely sees it
    task automatic pulse(input logic enc, input logic [1:0] ch);
        @(negedge sys_clk);
        if (enc) hsc_a[ch[0]] = 1'b1;
        else in_pin[ch] = 1'b1;
        repeat (5) @(negedge sys_clk);
        {in_pin, hsc_a} = 6'h00;
        repeat (5) @(negedge sys_clk);
    endtask
    // incremental encoder on counter 1: sets both phases per call, spaced past the synchroniser
    task automatic enc_step(input logic [1:0] ab);
        @(negedge sys_clk);
        {hsc_a[1], hsc_b[1]} = ab;
        repeat (4) @(negedge sys_clk);
    endtask
    // an absolute encoder sends its position Gray coded
    task automatic set_pos(input logic [11:0] pos);
        @(negedge sys_clk);
        abs_gray = pos ^ (pos >> 1);
        repeat (4) @(negedge sys_clk);
    endtask
endmodule // iicu_field_model
`default_nettype wire

// File: dv/iicu_props.sv
// iicu_props: timing checks on the command, input and timer ports of iicu_top.
// assumes one sys_clk domain and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module iicu_props (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic cmd_valid,
    input wire logic [1:0] cmd_ch,
    input wire logic [2:0] control_code,
    input wire logic [15:0] cmd_value,
    input wire logic tmr_start,
    input wire logic tmr_stop,
    input wire logic [1:0] tmr_sel,
    input wire logic [8:0] irq_ack,
    input wire logic [3:0] in_mask_q,
    input wire logic [3:0] in_cnt_mode_q,
    input wire logic [63:0] count_value_q,
    input wire logic [2:0] tmr_run_q,
    input wire logic [8:0] irq_pend_q,
    input wire logic [8:0] irq_req_q
);
    ////////////////////////////////////////////////////////////////
    // single domain, so clock and reset are given once
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    AST_UNMASK: assert property (cmd_valid && control_code == 3'h0 |=> !in_mask_q[$past(cmd_ch)])
        else $error("unmask command left the mask set");
    AST_LOAD: assert property (cmd_valid && control_code == 3'h3 |=> in_cnt_mode_q[$past(cmd_ch)] &&
        !in_mask_q[$past(cmd_ch)] && count_value_q[16*$past(cmd_ch) +: 16] == $past(cmd_value))
        else $error("load command did not set count and mode");
    AST_IGNORED: assert property (cmd_valid && control_code == 3'h2 |=> $stable(in_mask_q) && $stable(in_cnt_mode_q))
        else $error("unknown control code changed state");
    AST_DEC: assert property (in_cnt_mode_q[1] && !cmd_valid |=>
        count_value_q[31:16] == $past(count_value_q[31:16]) ||
        count_value_q[31:16] == $past(count_value_q[31:16]) - 16'h0001)
        else $error("counter mode count moved by more than one down");
    AST_ZERO: assert property (in_cnt_mode_q[1] && $past(count_value_q[31:16]) == 16'h0001 &&
        count_value_q[31:16] == 16'h0000 |-> ##[0:1] irq_pend_q[1])
        else $error("count reached zero without pending");
    AST_STICKY: assert property (1'b1 |=> ($past(irq_pend_q) & ~$past(irq_ack) & ~irq_pend_q) == 9'h000)
        else $error("pending flag lost without acknowledge");
    AST_REQ: assert property ((irq_req_q & ~irq_pend_q) == 9'h000)
        else $error("request raised without pending");
    AST_TSTART: assert property (tmr_start && tmr_sel != 2'h3 |=> tmr_run_q[$past(tmr_sel)] ||
        irq_pend_q[3'h4 + $past(tmr_sel)])
        else $error("timer start did not run the timer");
    AST_TSTOP: assert property (tmr_stop && !tmr_start && tmr_sel != 2'h3 |=> !tmr_run_q[$past(tmr_sel)])
        else $error("timer stop left the timer running");
endmodule // iicu_props
bind iicu_top iicu_props chk_u (.sys_clk, .reset, .cmd_valid, .cmd_ch, .control_code, .cmd_value, .tmr_start,
    .tmr_stop, .tmr_sel, .irq_ack, .in_mask_q, .in_cnt_mode_q, .count_value_q, .tmr_run_q, .irq_pend_q, .irq_req_q);
`default_nettype wire

// File: dv/iicu_top_test.sv
// iicu_top_test: command sequences against iicu_top with expected values.
// assumes iicu_map.vh on the include path; inputs change on the falling edge.
`timescale 1ns/100ps
`default_nettype none
`include "iicu_map.vh"
module iicu_top_test;
    logic sys_clk, reset, cmd_valid, tmr_start, tmr_stop, tmr_oneshot, hsc_z, tbl_we, tbl_ctr, abs_deg_mode;
    logic [1:0] cmd_ch, tmr_sel, hsc_a, hsc_b, hsc_linear, tbl_idx, abs_res;
    logic [2:0] control_code, tmr_run_q;
    logic [3:0] in_pin, hsc_mode, hsc_mult, cmp_mode, in_mask_q, in_cnt_mode_q;
    logic [15:0] cmd_value, tmr_period, tbl_val, abs_value_q;
    logic [31:0] hsc_max, cmp_lo, cmp_hi, hsc_count_q;
    logic [11:0] abs_gray;
    logic [8:0] irq_ack, irq_pend_q, irq_req_q;
    logic [63:0] count_value_q;
    int err_total, checks_done, waited;
    iicu_top dut_u (.sys_clk, .reset, .in_pin, .cmd_valid, .cmd_ch, .control_code, .cmd_value, .tmr_start,
        .tmr_stop, .tmr_sel, .tmr_oneshot, .tmr_period, .hsc_a, .hsc_b, .hsc_z, .hsc_mode, .hsc_mult, .hsc_linear,
        .hsc_max, .tbl_we, .tbl_ctr, .tbl_idx, .tbl_val, .cmp_mode, .cmp_lo, .cmp_hi, .abs_gray, .abs_res,
        .abs_deg_mode, .irq_ack, .in_mask_q, .in_cnt_mode_q, .count_value_q, .tmr_run_q, .hsc_count_q,
        .irq_pend_q, .irq_req_q, .abs_value_q);
    iicu_field_model fld_u (.sys_clk, .in_pin, .hsc_a, .hsc_b, .abs_gray);
    ////////////////////////////////////////////////////////////////
    // four-state compare, so an unknown never matches
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmd(input logic [1:0] ch, input logic [2:0] cc, input logic [15:0] val);
        @(negedge sys_clk);
        {cmd_valid, cmd_ch, control_code, cmd_value} = {1'b1, ch, cc, val};
        @(negedge sys_clk);
        cmd_valid = 1'b0;
    endtask
    task automatic tmr(input logic [1:0] sel, input logic one, input logic [15:0] per, input logic stop);
        @(negedge sys_clk);
        {tmr_sel, tmr_oneshot, tmr_period, tmr_start, tmr_stop} = {sel, one, per, ~stop, stop};
        @(negedge sys_clk);
        {tmr_start, tmr_stop} = 2'h0;
    endtask
    task automatic ack(input int idx);
        @(negedge sys_clk);
        irq_ack[idx] = 1'b1;
        @(negedge sys_clk);
        irq_ack = 9'h000;
    endtask
    // bounded wait; cycles spent are left in waited
    task automatic wait_pend(input int idx);
        for (waited = 0; irq_pend_q[idx] !== 1'b1 && waited < 600; waited++) @(negedge sys_clk);
        chk(irq_pend_q[idx], 1'b1);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // clock and watchdog; the run needs about 800 cycles
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        #100000;
        err_total++;
        wrap_up();
    end
    // main sequence; timer 2 stays idle since counter 0 is in use
    initial begin
        {reset, err_total, checks_done, cmd_valid, cmd_ch, control_code, cmd_value, irq_ack} = '1;
        {err_total, checks_done, cmd_valid, cmd_ch, control_code, cmd_value, irq_ack, tmr_start, tmr_stop} = '0;
        {tmr_sel, tmr_oneshot, tmr_period, hsc_z, hsc_mult, hsc_linear, tbl_we, tbl_ctr, tbl_idx} = '0;
        {tbl_val, cmp_mode, cmp_lo, cmp_hi, abs_res, abs_deg_mode} = '0;
        {hsc_mode, hsc_max} = {4'h3, 32'hffffffff};
        repeat (10) @(posedge sys_clk);
        @(negedge sys_clk);
        reset = 1'b0;
        chk(in_mask_q, 4'hf);
        fld_u.pulse(1'b0, 2'h0);
        chk(irq_pend_q[1:0] | {irq_req_q[0], 1'b0}, 2'h1);
        cmd(2'h0, `IICU_CC_UNMASK, 16'h0000);
        @(negedge sys_clk); // request follows the mask register one cycle later
        chk(irq_req_q[0], 1'b1);
        ack(0);
        chk(irq_pend_q[0], 1'b0);
        $display("test input interrupt done");
        cmd(2'h1, `IICU_CC_LOAD, 16'h0002);
        chk({in_cnt_mode_q[1], in_mask_q[1], count_value_q[31:16]}, {2'h2, 16'h0002});
        fld_u.pulse(1'b0, 2'h1);
        chk({irq_pend_q[1], count_value_q[31:16]}, 17'h00001);
        fld_u.pulse(1'b0, 2'h1);
        chk({irq_pend_q[1], count_value_q[31:16]}, 17'h10000);
        cmd(2'h2, `IICU_CC_LOAD, 16'h0005);
        cmd(2'h2, `IICU_CC_MASK, 16'h0000);
        fld_u.pulse(1'b0, 2'h2);
        chk({irq_req_q[2], count_value_q[47:32]}, 17'h00004);
        cmd(2'h3, 3'h2, 16'h0007);
        chk({in_cnt_mode_q[3], in_mask_q[3]}, 2'h1);
        $display("test counter mode done");
        tmr(2'h1, 1'b1, 16'h0002, 1'b0);
        chk(tmr_run_q[1], 1'b1);
        wait_pend(5);
        chk(tmr_run_q[1], 1'b0);
        tmr(2'h0, 1'b0, 16'h0002, 1'b0);
        wait_pend(4);
        ack(4);
        wait_pend(4);
        chk(waited + 2, 2 * `IICU_TICK_CYC);
        tmr(2'h0, 1'b0, 16'h0002, 1'b1);
        chk(tmr_run_q[0], 1'b0);
        $display("test interval timers done");
        for (int i = 0; i < 4; i++) begin
            @(negedge sys_clk);
            {tbl_we, tbl_idx, tbl_val} = {1'b1, 2'(i), (i == 0) ? 16'h0003 : 16'h00f0};
        end
        @(negedge sys_clk);
        {tbl_we, cmp_mode} = {1'b0, `IICU_CM_TGT};
        repeat (2) fld_u.pulse(1'b1, 2'h0);
        chk(irq_pend_q[7], 1'b0);
        fld_u.pulse(1'b1, 2'h0);
        chk({irq_pend_q[7], hsc_count_q[15:0]}, 17'h10003);
        {cmp_mode, cmp_lo, cmp_hi} = {`IICU_CM_RNG, 32'h00000002, 32'h00000004};
        ack(7);
        repeat (2) @(negedge sys_clk);
        chk(irq_pend_q[7], 1'b1);
        repeat (2) fld_u.pulse(1'b1, 2'h0);
        ack(7);
        repeat (2) @(negedge sys_clk);
        chk({irq_pend_q[7], hsc_count_q[15:0]}, 17'h00005);
        hsc_z = 1'b1;
        repeat (3) @(negedge sys_clk);
        chk(hsc_count_q[15:0], 16'h0000);
        hsc_z = 1'b0;
        // counter 1: x4 quadrature, linear then ring range, then pulse plus direction
        {hsc_mode[3:2], hsc_mult[3:2], hsc_linear[1], hsc_max[31:16]} = {`IICU_HM_QUAD, 2'h2, 1'b1, 16'h0005};
        fld_u.enc_step(2'h2);
        fld_u.enc_step(2'h3);
        fld_u.enc_step(2'h1);
        fld_u.enc_step(2'h0);
        chk(hsc_count_q[31:16], 16'h0004);
        fld_u.enc_step(2'h2);
        fld_u.enc_step(2'h3);
        chk(hsc_count_q[31:16], 16'h0005);
        hsc_linear[1] = 1'b0;
        fld_u.enc_step(2'h1);
        chk(hsc_count_q[31:16], 16'h0000);
        fld_u.enc_step(2'h3);
        chk(hsc_count_q[31:16], 16'h0005);
        hsc_mode[3:2] = `IICU_HM_PDIR;
        fld_u.enc_step(2'h0);
        fld_u.enc_step(2'h2);
        chk(hsc_count_q[31:16], 16'h0004);
        $display("test pulse counter done");
        {abs_res, abs_deg_mode} = {`IICU_RES_8, 1'b1};
        fld_u.set_pos(12'h040);
        chk(abs_value_q, 16'h005a);
        abs_deg_mode = 1'b0;
        fld_u.set_pos(12'h0c8);
        chk(abs_value_q, 16'h0200);
        abs_res = `IICU_RES_10;
        fld_u.set_pos(12'h3ff);
        chk(abs_value_q, 16'h1023);
        $display("test absolute encoder done");
        wrap_up();
    end
endmodule // iicu_top_test
`default_nettype wire

// File: pkg/iicu_map.vh
// iicu_map.vh: constants for the input, interval timer and counter unit.
// assumes a 100 MHz sys_clk; included by rtl/iicu_top.v by bare name.
// How it works
// [RULE_01] four built-in inputs request interrupts on their off-to-on change
// [RULE_02] an input interrupt stays masked until control code 000 clears its mask
// [RULE_03] scheduled timer mode requests interrupts repeatedly at the commanded period
// [RULE_04] three interval timers 0 to 2; one-shot mode interrupts once then stops
// [RULE_05] host never runs interval timer 2 while high-speed counter 0 is used
// [RULE_06] counter mode decrements on each input rise, up to 1 kHz, interrupts at zero
// [RULE_07] control code 003 loads the counter-mode set value and clears the mask
// [RULE_08] counter-mode channels count with requests masked, count still readable
// [RULE_09] target mode requests when the count equals any comparison table entry
// [RULE_10] range mode requests while the count lies between lower and upper limit
// [RULE_11] counter 0 counts quadrature up to 2.5 kHz or incrementing up to 5 kHz
// [RULE_12] expansion counter decodes quadrature with multiplication one, two or four
// [RULE_13] expansion counter also takes pulse plus direction and up/down pulse inputs
// [RULE_14] expansion counter range is ring, wrapping, or linear, bounded
// [RULE_15] absolute value is given as decimal digits or degrees, 8, 10 or 12 bit
// [RULE_16] absolute position is taken from a parallel Gray-coded word
// [RULE_17] host sets the absolute resolution equal to the encoder bit width
// [RULE_18] Gray to binary by running xor from the top bit, masked to resolution
// [RULE_19] each source latches a pending flag held until acknowledged
`ifndef IICU_MAP_VH
`define IICU_MAP_VH
`define IICU_CC_UNMASK 3'h0
`define IICU_CC_MASK 3'h1
`define IICU_CC_LOAD 3'h3
`define IICU_HM_QUAD 2'h0
`define IICU_HM_PDIR 2'h1
`define IICU_HM_UPDN 2'h2
`define IICU_HM_INC 2'h3
`define IICU_MUL_X1 2'h0
`define IICU_MUL_X2 2'h1
`define IICU_CM_OFF 2'h0
`define IICU_CM_TGT 2'h1
`define IICU_CM_RNG 2'h2
`define IICU_RES_8 2'h0
`define IICU_RES_10 2'h1
`define IICU_CLK_NS 10
`define IICU_TICK_NS 1000
`define IICU_TICK_CYC (`IICU_TICK_NS / `IICU_CLK_NS)
`define IICU_IRQ_TMR 4
`define IICU_IRQ_HSC 7
`define IICU_TBL_N 4
`define IICU_DEG 360
`endif

// File: rtl/iicu_top.v
// iicu_top: input interrupts, input counters, interval timers, two pulse
// counters with comparison, absolute Gray encoder path.
// assumes pins are asynchronous to sys_clk; host controls are on sys_clk.
`timescale 1ns/100ps
`default_nettype none
`include "iicu_map.vh"
module iicu_top (
    input wire sys_clk,
    input wire reset,
    input wire [3:0] in_pin,
    input wire cmd_valid,
    input wire [1:0] cmd_ch,
    input wire [2:0] control_code,
    input wire [15:0] cmd_value,
    input wire tmr_start,
    input wire tmr_stop,
    input wire [1:0] tmr_sel,
    input wire tmr_oneshot,
    input wire [15:0] tmr_period,
    input wire [1:0] hsc_a,
    input wire [1:0] hsc_b,
    input wire hsc_z,
    input wire [3:0] hsc_mode,
    input wire [3:0] hsc_mult,
    input wire [1:0] hsc_linear,
    input wire [31:0] hsc_max,
    input wire tbl_we,
    input wire tbl_ctr,
    input wire [1:0] tbl_idx,
    input wire [15:0] tbl_val,
    input wire [3:0] cmp_mode,
    input wire [31:0] cmp_lo,
    input wire [31:0] cmp_hi,
    input wire [11:0] abs_gray,
    input wire [1:0] abs_res,
    input wire abs_deg_mode,
    input wire [8:0] irq_ack,
    output reg [3:0] in_mask_q,
    output reg [3:0] in_cnt_mode_q,
    output reg [63:0] count_value_q,
    output reg [2:0] tmr_run_q,
    output reg [31:0] hsc_count_q,
    output reg [8:0] irq_pend_q,
    output reg [8:0] irq_req_q,
    output reg [15:0] abs_value_q
);

////////////////////////////////////////////////////////////////////////
// pin synchronisers: first stage feeds only the second
reg [3:0] in_s1_q, in_s2_q, in_s3_q;
reg [1:0] a_s1_q, a_s2_q, a_s3_q, b_s1_q, b_s2_q, b_s3_q;
reg z_s1_q, z_s2_q;
reg [11:0] g_s1_q, g_s2_q;
always @(posedge sys_clk) begin
    if (reset) begin
        in_s1_q <= 4'h0;
        in_s2_q <= 4'h0;
        in_s3_q <= 4'h0;
        a_s1_q <= 2'h0;
        a_s2_q <= 2'h0;
        a_s3_q <= 2'h0;
        b_s1_q <= 2'h0;
        b_s2_q <= 2'h0;
        b_s3_q <= 2'h0;
        z_s1_q <= 1'b0;
        z_s2_q <= 1'b0;
        g_s1_q <= 12'h000;
        g_s2_q <= 12'h000;
    end else begin
        // third stage only keeps the previous sample for edge detection
        in_s1_q <= in_pin;
        in_s2_q <= in_s1_q;
        in_s3_q <= in_s2_q;
        a_s1_q <= hsc_a;
        a_s2_q <= a_s1_q;
        a_s3_q <= a_s2_q;
        b_s1_q <= hsc_b;
        b_s2_q <= b_s1_q;
        b_s3_q <= b_s2_q;
        z_s1_q <= hsc_z;
        z_s2_q <= z_s1_q;
        g_s1_q <= abs_gray;
        g_s2_q <= g_s1_q;
    end
end

// per-source set and enable, filled in by the channel loops below
wire [8:0] set_v;
wire [8:0] en_v;
wire [3:0] in_rise = in_s2_q & ~in_s3_q;

////////////////////////////////////////////////////////////////////////
// input channels: interrupt mode or decrementing counter mode
genvar i;
generate
    for (i = 0; i < 4; i = i + 1) begin : g_in
        wire hit = cmd_valid && ({30'h0, cmd_ch} == i);
        wire [15:0] cv = count_value_q[16*i +: 16];
        // unmask and load outrank counting; unmask returns the channel to interrupt mode
        always @(posedge sys_clk) begin
            if (reset) begin
                in_mask_q[i] <= 1'b1;
                in_cnt_mode_q[i] <= 1'b0;
                count_value_q[16*i +: 16] <= 16'h0000;
            end else if (hit && control_code == `IICU_CC_UNMASK) begin
                in_mask_q[i] <= 1'b0; // RULE_02
                in_cnt_mode_q[i] <= 1'b0;
            end else if (hit && control_code == `IICU_CC_LOAD) begin
                in_mask_q[i] <= 1'b0; // RULE_07
                in_cnt_mode_q[i] <= 1'b1;
                count_value_q[16*i +: 16] <= cmd_value;
            end else begin
                if (hit && control_code == `IICU_CC_MASK)
                    in_mask_q[i] <= 1'b1; // RULE_08
                // counting continues while masked, so the value stays readable
                if (in_cnt_mode_q[i] && in_rise[i] && cv != 16'h0000)
                    count_value_q[16*i +: 16] <= cv - 16'h0001; // RULE_06
            end
        end
        // a rise in the load cycle is not counted (the load defines the count) but still sets pending by the old mode
        assign set_v[i] = in_rise[i] & (~in_cnt_mode_q[i] | (cv == 16'h0001)); // RULE_01 RULE_06
        assign en_v[i] = ~in_mask_q[i]; // RULE_02
    end
endgenerate

////////////////////////////////////////////////////////////////////////
// interval timers on a shared 1 us tick; period counts ticks
reg [6:0] tick_q;
// compared at full width so the count constant is never cut silently
wire [31:0] tick_last = `IICU_TICK_CYC - 1;
wire tick = ({25'h0, tick_q} == tick_last);
always @(posedge sys_clk) begin
    if (reset || tick)
        tick_q <= 7'h00;
    else
        tick_q <= tick_q + 7'h01;
end

genvar t;
generate
    for (t = 0; t < 3; t = t + 1) begin : g_tmr
        reg os_q;
        reg [15:0] per_q, cnt_q;
        wire sel = ({30'h0, tmr_sel} == t);
        wire due = tick && tmr_run_q[t] && (cnt_q + 16'h0001 >= per_q);
        // start outranks stop; the free tick makes the first period up to one tick short
        always @(posedge sys_clk) begin
            if (reset) begin
                tmr_run_q[t] <= 1'b0;
                os_q <= 1'b0;
                per_q <= 16'h0001;
                cnt_q <= 16'h0000;
            end else if (tmr_start && sel) begin
                tmr_run_q[t] <= 1'b1; // RULE_04
                os_q <= tmr_oneshot;
                // zero period is taken as one tick
                per_q <= (tmr_period == 16'h0000) ? 16'h0001 : tmr_period; // RULE_03
                cnt_q <= 16'h0000;
            end else if (tmr_stop && sel) begin
                tmr_run_q[t] <= 1'b0;
            end else if (due) begin
                cnt_q <= 16'h0000; // RULE_03
                if (os_q)
                    tmr_run_q[t] <= 1'b0; // RULE_04
            end else if (tick && tmr_run_q[t]) begin
                cnt_q <= cnt_q + 16'h0001;
            end
        end
        assign set_v[`IICU_IRQ_TMR + t] = due; // RULE_03 RULE_04
        assign en_v[`IICU_IRQ_TMR + t] = 1'b1;
    end
endgenerate

////////////////////////////////////////////////////////////////////////
// pulse counters: 0 is built-in (quad x1 or incrementing, z clears),
// 1 is the expansion counter with all modes and ring/linear range
reg [15:0] tbl_q [0:7];
always @(posedge sys_clk) begin
    if (tbl_we)
        tbl_q[{tbl_ctr, tbl_idx}] <= tbl_val; // RULE_09
end

genvar k;
generate
    for (k = 0; k < 2; k = k + 1) begin : g_hsc
        reg moved_q;
        reg up, dn, tmatch;
        integer n;
        wire a = a_s2_q[k];
        wire b = b_s2_q[k];
        wire ea = a ^ a_s3_q[k];
        wire eb = b ^ b_s3_q[k];
        wire ra = a & ~a_s3_q[k];
        wire rb = b & ~b_s3_q[k];
        wire [1:0] mraw = hsc_mode[2*k +: 2];
        // counter 0 knows only quadrature x1 and incrementing
        wire [1:0] md = (k == 0 && mraw != `IICU_HM_INC) ? `IICU_HM_QUAD : mraw; // RULE_11
        wire [1:0] mul = (k == 0) ? `IICU_MUL_X1 : hsc_mult[2*k +: 2];
        wire [15:0] c = hsc_count_q[16*k +: 16];
        wire [15:0] mx = hsc_max[16*k +: 16];
        wire lin = hsc_linear[k];
        // direction decode per input mode, then the comparison table search
        always @* begin
            up = 1'b0;
            dn = 1'b0;
            case (md)
                `IICU_HM_QUAD: begin
                    // x4 counts all edges, x2 the a edges, x1 only a rises
                    if ((mul == `IICU_MUL_X1) ? ra : (mul == `IICU_MUL_X2) ? ea : (ea | eb)) begin // RULE_12
                        up = ea ? (a ^ b) : ~(a ^ b);
                        dn = ~up;
                    end
                end
                `IICU_HM_PDIR: begin
                    up = ra & b; // RULE_13
                    dn = ra & ~b;
                end
                `IICU_HM_UPDN: begin
                    up = ra & ~rb; // RULE_13
                    dn = rb & ~ra;
                end
                default: begin
                    up = ra; // RULE_11
                end
            endcase
            tmatch = 1'b0;
            for (n = 0; n < `IICU_TBL_N; n = n + 1)
                if (tbl_q[k * `IICU_TBL_N + n] == c)
                    tmatch = 1'b1;
        end
        // index pulse clears counter 0 only; linear range holds at its bounds
        always @(posedge sys_clk) begin
            if (reset || (k == 0 && z_s2_q)) begin
                hsc_count_q[16*k +: 16] <= 16'h0000;
                moved_q <= 1'b0;
            end else begin
                moved_q <= 1'b0;
                if (up && !(lin && c >= mx)) begin
                    hsc_count_q[16*k +: 16] <= (c >= mx) ? 16'h0000 : c + 16'h0001; // RULE_14
                    moved_q <= 1'b1;
                end else if (dn && !(lin && c == 16'h0000)) begin
                    hsc_count_q[16*k +: 16] <= (c == 16'h0000) ? mx : c - 16'h0001; // RULE_14
                    moved_q <= 1'b1;
                end
            end
        end
        wire [1:0] cm = cmp_mode[2*k +: 2];
        wire inrng = (c >= cmp_lo[16*k +: 16]) && (c <= cmp_hi[16*k +: 16]);
        // target fires once per arrival on a table value, range holds
        assign set_v[`IICU_IRQ_HSC + k] = (cm == `IICU_CM_TGT && moved_q && tmatch) // RULE_09
            || (cm == `IICU_CM_RNG && inrng); // RULE_10
        assign en_v[`IICU_IRQ_HSC + k] = 1'b1;
    end
endgenerate

////////////////////////////////////////////////////////////////////////
// pending flags: set wins over acknowledge in the same cycle
always @(posedge sys_clk) begin
    if (reset) begin
        irq_pend_q <= 9'h000;
        irq_req_q <= 9'h000;
    end else begin
        irq_pend_q <= (irq_pend_q & ~irq_ack) | set_v; // RULE_19
        irq_req_q <= ((irq_pend_q & ~irq_ack) | set_v) & en_v; // RULE_02 RULE_08
    end
end

////////////////////////////////////////////////////////////////////////
// absolute encoder: word is low-aligned, width set by abs_res
reg [11:0] wmask, bin;
reg [3:0] w;
reg [27:0] dd;
reg [31:0] deg;
integer m;
// product kept at 32 bits: the largest position times 360 fits with room
localparam [31:0] DEG_MUL = `IICU_DEG;
always @* begin
    case (abs_res)
        `IICU_RES_8: begin // RULE_15
            wmask = 12'h0ff;
            w = 4'h8;
        end
        `IICU_RES_10: begin
            wmask = 12'h3ff;
            w = 4'ha;
        end
        default: begin
            wmask = 12'hfff;
            w = 4'hc;
        end
    endcase
    bin = 12'h000;
    bin[11] = g_s2_q[11] & wmask[11];
    // running xor from the top; bits above the width are masked off
    for (m = 10; m >= 0; m = m - 1)
        bin[m] = bin[m + 1] ^ (g_s2_q[m] & wmask[m]); // RULE_16 RULE_18
    bin = bin & wmask; // RULE_18
    // shift-and-add-3 to four decimal digits
    dd = {16'h0000, bin};
    for (m = 0; m < 12; m = m + 1) begin
        if (dd[15:12] > 4'h4) dd[15:12] = dd[15:12] + 4'h3;
        if (dd[19:16] > 4'h4) dd[19:16] = dd[19:16] + 4'h3;
        if (dd[23:20] > 4'h4) dd[23:20] = dd[23:20] + 4'h3;
        if (dd[27:24] > 4'h4) dd[27:24] = dd[27:24] + 4'h3;
        dd = {dd[26:0], 1'b0};
    end
    deg = ({20'h00000, bin} * DEG_MUL) >> w; // RULE_15
end

// registered so the output never shows the conversion ripple
always @(posedge sys_clk) begin
    if (reset)
        abs_value_q <= 16'h0000;
    else
        abs_value_q <= abs_deg_mode ? deg[15:0] : dd[27:12]; // RULE_15
end

endmodule // iicu_top
`default_nettype wire
